// ===== verilog/xcvr_debug_port.v
`timescale 1ns/100ps
`include "xcvr_debug_regs.vh"
// ----------------------------------------
// transceiver control and status debug port
// ----------------------------------------
module xcvr_debug_port #(
    parameter DEBUG_EN = 1,
    parameter RECONFIG_EN = 1,
    parameter LOW_END = 0,
    parameter PMA_DONE_CYCLES = `PMA_DONE_CYC
) (
    input wire clk_i,
    input wire rstn_i,
    input wire ce_i,
    input wire reconfig_clock_i,
    input wire reconfig_req_i,
    input wire reconfig_write_strobe_i,
    input wire [`RCFG_ADDR_W-1:0] reconfig_addr_i,
    input wire [`RCFG_DATA_W-1:0] reconfig_write_data_i,
    output wire [`RCFG_DATA_W-1:0] reconfig_read_data_o,
    output wire reconfig_ack_o,
    input wire tx_pma_reset_i,
    input wire tx_pcs_reset_i,
    input wire rx_pma_reset_i,
    input wire rx_pcs_reset_i,
    input wire rx_elastic_buffer_reset_i,
    input wire rx_low_power_eq_reset_i,
    input wire tx_output_inhibit_i,
    input wire tx_serial_i,
    output reg tx_serial_o,
    output reg rx_pma_reset_complete_o,
    output reg rx_reset_complete_o,
    output reg tx_reset_complete_o,
    output reg rx_eq_reset_o,
    output reg [`DMON_W-1:0] digital_monitor_bus_o
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    reg [6:0] in_s1_r, in_s2_r;
    wire [6:0] raw = {tx_output_inhibit_i, rx_low_power_eq_reset_i,
                      rx_elastic_buffer_reset_i, rx_pcs_reset_i,
                      rx_pma_reset_i, tx_pcs_reset_i, tx_pma_reset_i};
    // resets are asynchronous, so every level goes through two flops
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            in_s1_r <= 7'h00;
            in_s2_r <= 7'h00;
        end
        else if (ce_i)
        begin
            in_s1_r <= raw;
            in_s2_r <= in_s1_r;
        end
    end
    // debug option off: controls forced to their defaults
    wire [6:0] ctl = (DEBUG_EN != 0) ? in_s2_r : 7'h00;
    wire tx_pma_rst = ctl[0];
    wire tx_pcs_rst = ctl[1];
    wire rx_pma_rst = ctl[2];
    wire rx_pcs_rst = ctl[3];
    wire rx_buf_rst = ctl[4];
    wire lpm_rst = (LOW_END != 0) & ctl[5];
    wire inhibit = ctl[6];
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // true once a progress counter has run its full delay
    function at_limit;
        input [15:0] cnt;
        begin
            at_limit = (cnt == PMA_DONE_CYCLES[15:0]);
        end
    endfunction
    // ----------------------------------------
    // reset progress
    // ----------------------------------------
    reg [15:0] pma_cnt_r;
    reg [15:0] tx_cnt_r;
    reg [15:0] rx_cnt_r;
    wire tx_rst_any = tx_pma_rst || tx_pcs_rst;
    wire rx_rst_any = rx_pcs_rst || rx_buf_rst || lpm_rst;
    // pma progress restarts whenever the rx pma reset is held
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            pma_cnt_r <= 16'h0000;
            rx_pma_reset_complete_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (rx_pma_rst)
                pma_cnt_r <= 16'h0000;
            else if (!at_limit(pma_cnt_r))
                pma_cnt_r <= pma_cnt_r + 16'h0001;
            rx_pma_reset_complete_o <= !rx_pma_rst && at_limit(pma_cnt_r);
        end
    end
    // tx progress: either tx reset restarts the count
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            tx_cnt_r <= 16'h0000;
            tx_reset_complete_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (tx_rst_any)
                tx_cnt_r <= 16'h0000;
            else if (!at_limit(tx_cnt_r))
                tx_cnt_r <= tx_cnt_r + 16'h0001;
            tx_reset_complete_o <= !tx_rst_any && at_limit(tx_cnt_r);
        end
    end
    // rx done needs pma done and quiet pcs/buffer/eq resets, so a
    // late pma reset always pulls rx done down with it
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            rx_cnt_r <= 16'h0000;
            rx_reset_complete_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (rx_rst_any || !rx_pma_reset_complete_o)
                rx_cnt_r <= 16'h0000;
            else if (!at_limit(rx_cnt_r))
                rx_cnt_r <= rx_cnt_r + 16'h0001;
            rx_reset_complete_o <= rx_pma_reset_complete_o &&
                !rx_rst_any && at_limit(rx_cnt_r);
        end
    end
    // eq reset mirror, stays zero on variants that ignore it
    always @(posedge clk_i)
    begin
        if (!rstn_i)
            rx_eq_reset_o <= 1'b0;
        else if (ce_i)
            rx_eq_reset_o <= lpm_rst;
    end
    // ----------------------------------------
    // serial output and monitor
    // ----------------------------------------
    // inhibit holds the line low; tx reset also parks it
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            tx_serial_o <= 1'b0;
            digital_monitor_bus_o <= `DMON_RST;
        end
        else if (ce_i)
        begin
            tx_serial_o <= (inhibit || !tx_reset_complete_o) ? 1'b0 :
                tx_serial_i;
            // narrow monitor: only low bits carry status, upper read zero
            digital_monitor_bus_o <= {{(`DMON_W-`DMON_NARROW_W){1'b0}},
                rx_eq_reset_o, rx_buf_rst, rx_pcs_rst, rx_pma_rst,
                tx_pcs_rst, tx_pma_rst, rx_reset_complete_o,
                rx_pma_reset_complete_o};
        end
    end
    // ----------------------------------------
    // reconfiguration port
    // ----------------------------------------
    // access gated until rx reset done, guarding a careless user
    wire rcfg_en = (RECONFIG_EN != 0) && rx_reset_complete_o;
    reconfig_port #(
        .AW(`RCFG_ADDR_W),
        .DW(`RCFG_DATA_W)
    ) u_rcfg (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .enable_i(rcfg_en),
        .rclk_i(reconfig_clock_i),
        .req_i(reconfig_req_i),
        .we_i(reconfig_write_strobe_i),
        .addr_i(reconfig_addr_i),
        .wdata_i(reconfig_write_data_i),
        .rdata_o(reconfig_read_data_o),
        .ack_o(reconfig_ack_o)
    );
endmodule // xcvr_debug_port

// ===== verilog/xcvr_debug_regs.vh
`ifndef XCVR_DEBUG_REGS_VH
`define XCVR_DEBUG_REGS_VH
// reconfiguration port widths
`define RCFG_ADDR_W 9
`define RCFG_DATA_W 16
// digital monitor width and the narrow width of some families
`define DMON_W 17
`define DMON_NARROW_W 8
// reconfiguration access latency, less one, in reconfig clock edges
`define RCFG_LAT_EDGES 4'h3
// reconfiguration space size (words)
`define RCFG_DEPTH 512
// reset values
`define RCFG_RDATA_RST 16'h0000
`define DMON_RST 17'h00000
// pma reset completion delay in ns and derived core cycles
`define PMA_DONE_NS 100
`define CLK_PERIOD_NS 5
`define PMA_DONE_CYC ((`PMA_DONE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ===== verilog/reconfig_port.v
`timescale 1ns/100ps
`include "xcvr_debug_regs.vh"
// ----------------------------------------
// reconfiguration port, sampled on clk_i
// ----------------------------------------
module reconfig_port #(
    parameter AW = `RCFG_ADDR_W,
    parameter DW = `RCFG_DATA_W
) (
    input wire clk_i,
    input wire rstn_i,
    input wire ce_i,
    input wire enable_i,
    input wire rclk_i,
    input wire req_i,
    input wire we_i,
    input wire [AW-1:0] addr_i,
    input wire [DW-1:0] wdata_i,
    output reg [DW-1:0] rdata_o,
    output reg ack_o
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    reg rclk_s1_r, rclk_s2_r, rclk_d_r;
    reg busy_r, we_r;
    reg [3:0] cnt_r;
    reg [AW-1:0] addr_r;
    reg [DW-1:0] wdata_r;
    wire rise = rclk_s2_r & ~rclk_d_r;
    // two-flop sync of reconfig clock, then edge find
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            rclk_s1_r <= 1'b0;
            rclk_s2_r <= 1'b0;
            rclk_d_r <= 1'b0;
        end
        else if (ce_i)
        begin
            rclk_s1_r <= rclk_i;
            rclk_s2_r <= rclk_s1_r;
            rclk_d_r <= rclk_s2_r;
        end
    end
    // one access at a time; ack is a one-reconfig-edge-wide pulse
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            busy_r <= 1'b0;
            we_r <= 1'b0;
            cnt_r <= 4'h0;
            addr_r <= {AW{1'b0}};
            wdata_r <= {DW{1'b0}};
            rdata_o <= `RCFG_RDATA_RST;
            ack_o <= 1'b0;
        end
        else if (ce_i && rise)
        begin
            ack_o <= 1'b0;
            if (!busy_r)
            begin
                if (req_i && enable_i)
                begin
                    busy_r <= 1'b1;
                    we_r <= we_i;
                    addr_r <= addr_i;
                    wdata_r <= wdata_i;
                    cnt_r <= `RCFG_LAT_EDGES;
                end
            end
            else if (cnt_r != 4'h0)
                cnt_r <= cnt_r - 4'h1;
            else
            begin
                busy_r <= 1'b0;
                ack_o <= 1'b1;
                if (we_r)
                    mem[addr_r] <= wdata_r;
                else
                    rdata_o <= mem[addr_r];
            end
        end
    end
endmodule // reconfig_port

// ===== testbench/debug_port_monitor.sv
`timescale 1ns/100ps
// ----------------------------------------
// port checks for the debug port
// ----------------------------------------
module debug_port_monitor #(
    parameter LOW_END = 0
) (
    input logic clk_i,
    input logic rstn_i,
    input logic tx_pcs_reset_i,
    input logic rx_pma_reset_i,
    input logic tx_output_inhibit_i,
    input logic tx_serial_o,
    input logic rx_pma_reset_complete_o,
    input logic rx_reset_complete_o,
    input logic rx_eq_reset_o,
    input logic reconfig_ack_o,
    input logic [15:0] reconfig_read_data_o,
    input logic [16:0] digital_monitor_bus_o
);
    // inputs pass two sync flops and one output flop, so allow 5 cycles
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    ack_width_a: assert property (
        $rose(reconfig_ack_o) |-> reconfig_ack_o[*8] ##[1:3] !reconfig_ack_o)
        else $error("ack pulse width wrong");
    ack_after_done_a: assert property (
        $rose(reconfig_ack_o) |-> rx_reset_complete_o)
        else $error("ack before rx reset done");
    rdata_hold_a: assert property (
        $changed(reconfig_read_data_o) |-> $rose(reconfig_ack_o))
        else $error("read data moved without ack");
    mon_upper_a: assert property (
        digital_monitor_bus_o[16:8] == 9'h000)
        else $error("monitor upper bits set");
    eq_ignored_a: assert property (
        LOW_END != 0 || !rx_eq_reset_o)
        else $error("eq reset passed on wrong variant");
    inhibit_quiet_a: assert property (
        tx_output_inhibit_i[*5] |-> !tx_serial_o)
        else $error("serial output moves under inhibit");
    pma_clear_a: assert property (
        rx_pma_reset_i[*5] |-> !rx_pma_reset_complete_o)
        else $error("pma done high under pma reset");
    mon_pcs_a: assert property (
        tx_pcs_reset_i[*5] |-> digital_monitor_bus_o[3])
        else $error("monitor misses tx pcs reset");
endmodule // debug_port_monitor

bind xcvr_debug_port debug_port_monitor #(.LOW_END(LOW_END))
    debug_port_monitor_inst (.*);

// ===== testbench/reconfig_user.sv
`timescale 1ns/100ps
// ----------------------------------------
// user reconfiguration controller model
// ----------------------------------------
module reconfig_user (
    input logic reconfig_clock_i,
    input logic rx_reset_complete_i,
    input logic reconfig_ack_i,
    output logic reconfig_req_o = 0,
    output logic reconfig_write_strobe_o = 0,
    output logic [8:0] reconfig_addr_o = 9'h000,
    output logic [15:0] reconfig_write_data_o = 16'h0000
);
    logic done_s1_r = 0, done_s2_r = 0;
    // reset done comes from the core clock, so two flops first
    always @(posedge reconfig_clock_i)
    begin
        done_s1_r <= rx_reset_complete_i;
        done_s2_r <= done_s1_r;
    end
    // one access at a time; ok stays low if no ack came in time
    task xfer(input logic w, input logic [8:0] a, input logic [15:0] d,
              output logic ok);
        int n;
        n = 0;
        @(posedge reconfig_clock_i);
        while (done_s2_r !== 1'b1 && n++ < 40)
            @(posedge reconfig_clock_i);
        #1;
        reconfig_req_o = 1'b1;
        reconfig_write_strobe_o = w;
        reconfig_addr_o = a;
        reconfig_write_data_o = d;
        n = 0;
        do @(posedge reconfig_clock_i);
        while (reconfig_ack_i !== 1'b1 && n++ < 10);
        ok = reconfig_ack_i;
        #1;
        reconfig_req_o = 1'b0;
        // released lines show the inverse, not a stale value
        reconfig_addr_o = ~a;
        reconfig_write_data_o = ~d;
    endtask
endmodule // reconfig_user

// ===== testbench/xcvr_debug_port_bench.sv
`timescale 1ns/100ps
// ----------------------------------------
// bench for the transceiver debug port
// ----------------------------------------
module xcvr_debug_port_bench;
    logic clk_i = 0, rstn_i = 0, rclk = 0, eq = 0, inh = 0, txd = 0;
    logic req, we, ack, txo, pdone, rdone, tdone, eqo, ok;
    logic [4:0] rv = 5'h00;
    logic [8:0] addr;
    logic [15:0] wd, rd;
    logic [16:0] mon;
    int fails = 0, samples_checked = 0;
    // core clock, and a free reconfig clock at an unrelated phase
    always #2.5 clk_i = ~clk_i;
    initial #7 forever #24 rclk = ~rclk;
    xcvr_debug_port xcvr_debug_port_inst (.clk_i(clk_i), .rstn_i(rstn_i),
        .ce_i(1'b1), .reconfig_clock_i(rclk), .reconfig_req_i(req),
        .reconfig_write_strobe_i(we), .reconfig_addr_i(addr),
        .reconfig_write_data_i(wd), .reconfig_read_data_o(rd),
        .reconfig_ack_o(ack), .tx_pma_reset_i(rv[0]),
        .tx_pcs_reset_i(rv[1]), .rx_pma_reset_i(rv[2]),
        .rx_pcs_reset_i(rv[3]), .rx_elastic_buffer_reset_i(rv[4]),
        .rx_low_power_eq_reset_i(eq), .tx_output_inhibit_i(inh),
        .tx_serial_i(txd), .tx_serial_o(txo),
        .rx_pma_reset_complete_o(pdone), .rx_reset_complete_o(rdone),
        .tx_reset_complete_o(tdone), .rx_eq_reset_o(eqo),
        .digital_monitor_bus_o(mon));
    reconfig_user reconfig_user_inst (.reconfig_clock_i(rclk),
        .rx_reset_complete_i(rdone), .reconfig_ack_i(ack),
        .reconfig_req_o(req), .reconfig_write_strobe_o(we),
        .reconfig_addr_o(addr), .reconfig_write_data_o(wd));
    task chk(input logic [16:0] got, input logic [16:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // bounded wait for the pma, rx and tx reset sequences to finish
    task wait_done;
        int n;
        n = 0;
        while ((pdone & rdone & tdone) !== 1'b1 && n++ < 300)
            tick(1);
        chk({pdone, rdone, tdone}, 3'h7);
    endtask
    task t_start;
        tick(2);
        chk({txo, pdone, rdone, tdone, eqo, ack}, 0);
        chk(mon, 0);
        chk(rd, 0);
        rstn_i = 1;
        wait_done();
        $display("start done");
    endtask
    task t_reconfig;
        reconfig_user_inst.xfer(1, 9'h000, 16'h5a3c, ok);
        chk(ok, 1);
        reconfig_user_inst.xfer(1, 9'h1ff, 16'hc3a5, ok);
        chk(ok, 1);
        reconfig_user_inst.xfer(0, 9'h000, 16'h0000, ok);
        chk({ok, rd}, {1'b1, 16'h5a3c});
        reconfig_user_inst.xfer(0, 9'h1ff, 16'h0000, ok);
        chk({ok, rd}, {1'b1, 16'hc3a5});
        $display("reconfig done");
    endtask
    task t_inhibit;
        txd = 1;
        tick(5);
        chk(txo, 1);
        inh = 1;
        tick(5);
        chk(txo, 0);
        inh = 0;
        tick(5);
        chk(txo, 1);
        $display("inhibit done");
    endtask
    task t_resets;
        for (int i = 0; i < 5; i++)
        begin
            rv = 5'h01 << i;
            tick(5);
            chk(mon[6:2], 5'h01 << i);
            rv = 5'h00;
            tick(5);
            wait_done();
        end
        eq = 1;
        tick(5);
        chk({eqo, mon[16:7]}, 0);
        $display("resets done");
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        t_start();
        t_reconfig();
        t_inhibit();
        t_resets();
        print_verdict();
    end
endmodule // xcvr_debug_port_bench
